//--- rtl/modem_serial_end.sv
// modem end (dce) of the host serial port with wishbone control registers
//
// Behaviour
// - both ports start at 115200 baud
// - framing is 8 data, no parity, 1 stop
// - low level means zero or asserted
// - drive rxd and cts, sample txd and rts
// - sample dtr, drive dsr, dcd, ri
// - port disabled while usb serves commands
// - aux mode: dcd/dtr data, ri/dsr flow
// - status pins are status or aux, never both
// - host holds rts low without flow control
// - multiplexed traffic uses hdlc-like frames
// - channel zero carries mux control only
// - channel one carries commands and sockets
// - channel two carries dial-up session data
// - channel three carries positioning data
`timescale 1ns/100ps
`include "serial_port_map.svh"
module modem_serial_end
	import serial_port_pkg::*;
#(
	parameter int BIT_CYC = `BIT_CYCLES,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	serial_link_if.modem link
);
	localparam int OVS = BIT_CYC / `OVS_RATE;
	typedef struct packed {
		logic [7:0] ctrl;
		logic ack;
		logic [31:0] rdat;
		tx_state_t tx_st;
		logic [15:0] tx_cnt;
		logic [2:0] tx_bit;
		logic [7:0] tx_sh;
		logic tx_line;
		rx_state_t rx_st;
		logic [15:0] rx_cnt;
		logic [3:0] rx_ph;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic [7:0] rx_buf;
		logic rx_valid;
		logic ferr;
		logic rx_s1;
		logic rx_s2;
		logic rts_s;
		logic dtr_s;
		logic [3:0] pins;
	} state_t;
	state_t q_ff;
	state_t nxt_q;
	logic en;
	logic aux;
	logic rx_in;
	logic flow_in;
	logic wr;
	logic rd;
	logic [7:0] tf_data;
	logic tf_valid;
	logic tf_ready;
	logic tf_in_ready;
	////////////////////////////////////////////////////////////////
	// transmit fifo fed by data register writes
	byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) i_byte_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_data_i(wb_dat_i[7:0]),
		.in_valid_i(wr && (wb_adr_i == `REG_TXDATA) && wb_sel_i[0]),
		.in_ready_o(tf_in_ready),
		.out_data_o(tf_data),
		.out_valid_o(tf_valid),
		.out_ready_i(tf_ready)
	);
	////////////////////////////////////////////////////////////////
	// usb path disables the port
	assign en = q_ff.ctrl[`CTRL_EN_BIT] & ~q_ff.ctrl[`CTRL_USB_BIT];
	assign aux = q_ff.ctrl[`CTRL_AUX_BIT];
	assign rx_in = q_ff.rx_s2;
	assign flow_in = ~q_ff.rts_s;
	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~q_ff.ack;
	assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~q_ff.ack;
	assign tf_ready = en && (q_ff.tx_st == TX_IDLE) && flow_in;
	// next state of the whole end
	always_comb begin
		nxt_q = q_ff;
		nxt_q.ack = wb_cyc_i & wb_stb_i & ~q_ff.ack;
		// aux mode swaps data pins onto status lines
		nxt_q.rx_s1 = aux ? link.dtr : link.txd;
		nxt_q.rx_s2 = q_ff.rx_s1;
		// the modem drives dsr itself, so aux flow comes in on the host's drive
		nxt_q.rts_s = aux ? link.dsr_in : link.rts;
		nxt_q.dtr_s = aux ? 1'b1 : link.dtr;
		// bus writes
		if (wr && wb_adr_i == `REG_CTRL && wb_sel_i[0]) begin
			nxt_q.ctrl = wb_dat_i[7:0];
		end
		if (rd) begin
			case (wb_adr_i)
				`REG_CTRL: nxt_q.rdat = {24'h0, q_ff.ctrl};
				`REG_STATUS: nxt_q.rdat = {24'h0, q_ff.pins[3:1], ~q_ff.dtr_s,
					~q_ff.rts_s, q_ff.ferr, q_ff.rx_valid, tf_in_ready};
				`REG_RXDATA: nxt_q.rdat = {24'h0, q_ff.rx_buf};
				default: nxt_q.rdat = 32'h0;
			endcase
		end
		// reading received data frees the buffer and clears the error, set wins
		if (rd && wb_adr_i == `REG_RXDATA) begin
			nxt_q.rx_valid = 1'b0;
			nxt_q.ferr = 1'b0;
		end
		// transmitter, 8n1 at the default rate
		case (q_ff.tx_st)
			TX_IDLE: begin
				nxt_q.tx_line = 1'b1;
				if (tf_ready && tf_valid) begin
					nxt_q.tx_sh = tf_data;
					nxt_q.tx_cnt = 16'(BIT_CYC - 1);
					nxt_q.tx_line = 1'b0;
					nxt_q.tx_st = TX_START;
				end
			end
			TX_START, TX_DATA, TX_STOP: begin
				if (q_ff.tx_cnt != 16'h0) begin
					nxt_q.tx_cnt = q_ff.tx_cnt - 16'h1;
				end else begin
					nxt_q.tx_cnt = 16'(BIT_CYC - 1);
					if (q_ff.tx_st == TX_START) begin
						nxt_q.tx_st = TX_DATA;
						nxt_q.tx_bit = 3'h0;
						nxt_q.tx_line = q_ff.tx_sh[0];
					end else if (q_ff.tx_st == TX_DATA) begin
						nxt_q.tx_sh = {1'b0, q_ff.tx_sh[7:1]};
						if (q_ff.tx_bit == 3'(`DATA_BITS - 1)) begin
							nxt_q.tx_st = TX_STOP;
							nxt_q.tx_line = 1'b1;
						end else begin
							nxt_q.tx_bit = q_ff.tx_bit + 3'h1;
							nxt_q.tx_line = q_ff.tx_sh[1];
						end
					end else begin
						nxt_q.tx_st = TX_IDLE;
					end
				end
			end
			default: nxt_q.tx_st = TX_IDLE;
		endcase
		// receiver, ticks of 1/16 bit, samples mid bit
		if (q_ff.rx_cnt != 16'h0) begin
			nxt_q.rx_cnt = q_ff.rx_cnt - 16'h1;
		end else begin
			nxt_q.rx_cnt = 16'(OVS - 1);
		end
		case (q_ff.rx_st)
			RX_IDLE: begin
				if (en && !rx_in) begin
					nxt_q.rx_st = RX_START;
					nxt_q.rx_ph = 4'h0;
					nxt_q.rx_cnt = 16'(OVS - 1);
				end
			end
			RX_START, RX_DATA, RX_STOP: begin
				if (q_ff.rx_cnt == 16'h0) begin
					nxt_q.rx_ph = q_ff.rx_ph + 4'h1;
					if (q_ff.rx_st == RX_START && q_ff.rx_ph == 4'(`OVS_RATE / 2 - 1)) begin
						nxt_q.rx_ph = 4'h0;
						nxt_q.rx_bit = 3'h0;
						nxt_q.rx_st = rx_in ? RX_IDLE : RX_DATA;
					end else if (q_ff.rx_ph == 4'(`OVS_RATE - 1) && q_ff.rx_st == RX_DATA) begin
						nxt_q.rx_sh = {rx_in, q_ff.rx_sh[7:1]};
						nxt_q.rx_bit = q_ff.rx_bit + 3'h1;
						if (q_ff.rx_bit == 3'(`DATA_BITS - 1)) begin
							nxt_q.rx_st = RX_STOP;
						end
					end else if (q_ff.rx_ph == 4'(`OVS_RATE - 1) && q_ff.rx_st == RX_STOP) begin
						nxt_q.rx_st = RX_IDLE;
						nxt_q.rx_buf = q_ff.rx_sh;
						nxt_q.rx_valid = 1'b1;
						if (!rx_in) begin
							nxt_q.ferr = 1'b1;
						end
					end
				end
			end
			default: nxt_q.rx_st = RX_IDLE;
		endcase
		// status lines driven only outside aux mode
		nxt_q.pins = {q_ff.ctrl[`CTRL_RI_BIT], q_ff.ctrl[`CTRL_DCD_BIT],
			q_ff.ctrl[`CTRL_DSR_BIT], 1'b0};
	end
	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_ff <= '0;
			q_ff.ctrl <= `CTRL_RESET;
			q_ff.tx_st <= TX_IDLE;
			q_ff.rx_st <= RX_IDLE;
			q_ff.tx_line <= 1'b1;
			q_ff.rx_s1 <= 1'b1;
			q_ff.rx_s2 <= 1'b1;
			q_ff.rts_s <= 1'b1;
			q_ff.dtr_s <= 1'b1;
		end else begin
			q_ff <= nxt_q;
		end
	end
	////////////////////////////////////////////////////////////////
	// pin outputs, low means asserted
	logic [4:0] pin_ff;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_ff <= 5'h1f;
		end else begin
			pin_ff[0] <= aux ? 1'b1 : nxt_q.tx_line;
			pin_ff[1] <= ~(en & ~aux & ~q_ff.rx_valid);
			// dsr, dcd, ri or aux data and flow
			pin_ff[2] <= aux ? 1'b1 : ~q_ff.pins[1];
			pin_ff[3] <= aux ? nxt_q.tx_line : ~q_ff.pins[2];
			pin_ff[4] <= aux ? ~(en & ~q_ff.rx_valid) : ~q_ff.pins[3];
		end
	end
	assign link.rxd = pin_ff[0];
	assign link.cts = pin_ff[1];
	assign link.dsr = pin_ff[2];
	assign link.dcd = pin_ff[3];
	assign link.ri = pin_ff[4];
	assign wb_ack_o = q_ff.ack;
	assign wb_dat_o = q_ff.rdat;
endmodule

//--- rtl/serial_port_map.svh
// offsets, framing constants and timing figures of the host serial port
`ifndef SERIAL_PORT_MAP_SVH
`define SERIAL_PORT_MAP_SVH
`define CLK_HZ 50000000
`define BAUD_DEFAULT 115200
`define BIT_CYCLES (`CLK_HZ / `BAUD_DEFAULT)
`define OVS_RATE 16
`define DATA_BITS 8
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_TXDATA 4'h8
`define REG_RXDATA 4'hc
`define CTRL_RESET 8'h01
`define CTRL_EN_BIT 0
`define CTRL_AUX_BIT 1
`define CTRL_USB_BIT 2
`define CTRL_DTR_BIT 3
`define CTRL_DSR_BIT 4
`define CTRL_DCD_BIT 5
`define CTRL_RI_BIT 6
`define ST_TXREADY 0
`define ST_RXVALID 1
`define ST_FERR 2
`define ST_RTS 3
`define ST_DTR 4
`define ST_DSR 5
`define ST_DCD 6
`define ST_RI 7
`define MUX_CH_CONTROL 2'h0
`define MUX_CH_COMMAND 2'h1
`define MUX_CH_DIALUP 2'h2
`define MUX_CH_GNSS 2'h3
`endif

//--- rtl/serial_port_pkg.sv
// types shared by both ends of the host serial port
package serial_port_pkg;
	typedef enum logic [3:0] {
		TX_IDLE = 4'b0001,
		TX_START = 4'b0010,
		TX_DATA = 4'b0100,
		TX_STOP = 4'b1000
	} tx_state_t;
	typedef enum logic [3:0] {
		RX_IDLE = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA = 4'b0100,
		RX_STOP = 4'b1000
	} rx_state_t;
	typedef enum logic [1:0] {
		CH_CONTROL = 2'h0,
		CH_COMMAND = 2'h1,
		CH_DIALUP = 2'h2,
		CH_GNSS = 2'h3
	} mux_channel_t;
endpackage

//--- rtl/serial_link_if.sv
// eight wires between the modem end and the host end; all lines low-active for control
`timescale 1ns/100ps
interface serial_link_if;
	logic rxd;
	logic txd;
	logic cts;
	logic rts;
	logic dtr;
	logic dsr;
	logic dcd;
	logic ri;
	// host side drive of the dsr pin, the flow input in aux mode
	logic dsr_in;
	modport modem (output rxd, output cts, output dsr, output dcd, output ri,
		input txd, input rts, input dtr, input dsr_in);
	modport host (input rxd, input cts, input dsr, input dcd, input ri,
		output txd, output rts, output dtr, output dsr_in);
endinterface

//--- rtl/byte_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/100ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0] cnt_ff;
	logic push;
	logic pop;
	////////////////////////////////////////////////////////////////
	// handshake terms
	assign in_ready_o = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_ff != '0);
	assign out_data_o = mem[rd_ff];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;
	// storage and pointers
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ff] <= in_data_i;
		end
		if (rst_i) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
			end
			if (pop) begin
				rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
			end
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

//--- rtl/host_serial_end.sv
// host end (dte) of the serial port: byte stream in and out, 8n1
`timescale 1ns/100ps
`include "serial_port_map.svh"
module host_serial_end
	import serial_port_pkg::*;
#(
	parameter int BIT_CYC = `BIT_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] tx_data_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	output logic [7:0] rx_data_o,
	output logic rx_valid_o,
	output logic dsr_on_o,
	serial_link_if.host link
);
	typedef struct packed {
		tx_state_t tx_st;
		logic [15:0] tx_cnt;
		logic [3:0] tx_bit;
		logic [7:0] tx_sh;
		logic txd;
		rx_state_t rx_st;
		logic [15:0] rx_cnt;
		logic [3:0] rx_bit;
		logic [7:0] rx_sh;
		logic [7:0] rx_out;
		logic rx_v;
		logic rdy;
		logic dsr_on;
	} hstate_t;
	hstate_t q_ff;
	hstate_t nxt_q;
	// serialiser and mid-bit sampler
	always_comb begin
		nxt_q = q_ff;
		nxt_q.rx_v = 1'b0;
		nxt_q.rdy = 1'b0;
		nxt_q.dsr_on = ~link.dsr;
		case (q_ff.tx_st)
			TX_IDLE: begin
				nxt_q.rdy = ~link.cts;
				if (q_ff.rdy && tx_valid_i) begin
					nxt_q.rdy = 1'b0;
					nxt_q.tx_sh = tx_data_i;
					nxt_q.txd = 1'b0;
					nxt_q.tx_cnt = 16'(BIT_CYC - 1);
					nxt_q.tx_bit = 4'h0;
					nxt_q.tx_st = TX_DATA;
				end
			end
			TX_DATA: begin
				if (q_ff.tx_cnt != 16'h0) begin
					nxt_q.tx_cnt = q_ff.tx_cnt - 16'h1;
				end else begin
					nxt_q.tx_cnt = 16'(BIT_CYC - 1);
					nxt_q.tx_bit = q_ff.tx_bit + 4'h1;
					// stop bit after the eighth data bit, then back to idle
					if (q_ff.tx_bit == 4'(`DATA_BITS + 1)) begin
						nxt_q.tx_st = TX_IDLE;
					end else if (q_ff.tx_bit == 4'(`DATA_BITS)) begin
						nxt_q.txd = 1'b1;
					end else begin
						nxt_q.txd = q_ff.tx_sh[q_ff.tx_bit[2:0]];
					end
				end
			end
			default: nxt_q.tx_st = TX_IDLE;
		endcase
		case (q_ff.rx_st)
			RX_IDLE: begin
				if (!link.rxd) begin
					nxt_q.rx_cnt = 16'(BIT_CYC + BIT_CYC / 2 - 1);
					nxt_q.rx_bit = 4'h0;
					nxt_q.rx_st = RX_DATA;
				end
			end
			RX_DATA: begin
				if (q_ff.rx_cnt != 16'h0) begin
					nxt_q.rx_cnt = q_ff.rx_cnt - 16'h1;
				end else begin
					nxt_q.rx_cnt = 16'(BIT_CYC - 1);
					nxt_q.rx_bit = q_ff.rx_bit + 4'h1;
					if (q_ff.rx_bit == 4'(`DATA_BITS)) begin
						nxt_q.rx_st = RX_IDLE;
						nxt_q.rx_out = q_ff.rx_sh;
						nxt_q.rx_v = link.rxd;
					end else begin
						nxt_q.rx_sh = {link.rxd, q_ff.rx_sh[7:1]};
					end
				end
			end
			default: nxt_q.rx_st = RX_IDLE;
		endcase
	end
	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_ff <= '0;
			q_ff.tx_st <= TX_IDLE;
			q_ff.rx_st <= RX_IDLE;
			q_ff.txd <= 1'b1;
		end else begin
			q_ff <= nxt_q;
		end
	end
	// rts, dtr and dsr drive held on
	assign link.rts = rst_i;
	assign link.dtr = rst_i;
	assign link.dsr_in = rst_i;
	assign link.txd = q_ff.txd;
	assign tx_ready_o = q_ff.rdy;
	assign rx_data_o = q_ff.rx_out;
	assign rx_valid_o = q_ff.rx_v;
	assign dsr_on_o = q_ff.dsr_on;
endmodule

//--- test/host_serial_port_with_mux_chk.sv
// assertions on the wires between the modem end and the host end
`timescale 1ns/100ps
module host_serial_port_with_mux_chk #(
	parameter int BIT_CYC = 32
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic rxd,
	input wire logic txd,
	input wire logic cts,
	input wire logic rts,
	input wire logic dtr,
	input wire logic dsr,
	input wire logic dcd,
	input wire logic ri
);
	localparam int FRAME = 10 * BIT_CYC - 1;
	localparam int MID = BIT_CYC / 2;
	logic [1:0] prev_ff;
	int cnt_ff [2];
	////////////////////////////////////////////////////////////////
	// cycles left in the frame on rxd (0) and txd (1)
	always_ff @(posedge clk_i) begin
		prev_ff <= {txd, rxd};
		for (int i = 0; i < 2; i++) begin
			if (rst_i) begin
				cnt_ff[i] <= 0;
			end else if (cnt_ff[i] != 0) begin
				cnt_ff[i] <= cnt_ff[i] - 1;
			end else if (prev_ff[i] && !(i == 1 ? txd : rxd)) begin
				cnt_ff[i] <= FRAME;
			end
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// modem lines and txd rest at the off level when reset ends, rts and dtr stay on
	reset_off_a: assert property ($fell(rst_i) |-> rxd && cts && dsr && dcd && ri)
		else $error("modem lines not off after reset");
	host_idle_a: assert property ($fell(rst_i) |-> txd)
		else $error("txd not idle after reset");
	host_on_a: assert property (!$past(rst_i) |-> !rts && !dtr)
		else $error("rts or dtr not held on");
	// stop bit is high, bits hold for a whole bit time
	rx_stop_a: assert property (cnt_ff[0] == MID + 1 |-> rxd [*2])
		else $error("rxd stop bit low");
	tx_stop_a: assert property (cnt_ff[1] == MID |-> txd)
		else $error("txd stop bit low");
	rx_hold_a: assert property (cnt_ff[0] != 0 && cnt_ff[0] % BIT_CYC != 0 |-> $stable(rxd))
		else $error("rxd changed inside a bit");
	tx_hold_a: assert property (cnt_ff[1] != 0 && cnt_ff[1] % BIT_CYC != 0 |-> $stable(txd))
		else $error("txd changed inside a bit");
	rts_gate_a: assert property (cnt_ff[0] == 0 && prev_ff[0] && !rxd |-> !rts)
		else $error("frame started while rts off");
	rx_frame_c: cover property (cnt_ff[0] == 1);
	tx_frame_c: cover property (cnt_ff[1] == 1);
	cts_busy_c: cover property ($rose(cts));
endmodule

//--- test/host_serial_port_with_mux_tb_top.sv
// self-checking bench joining the modem end and the host end
`timescale 1ns/100ps
`include "serial_port_map.svh"
module host_serial_port_with_mux_tb_top;
	localparam int BC = 32;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic we = 1'b0;
	logic [1:0] cyc = 2'h0;
	logic [1:0] ack;
	logic [31:0] rdat [2];
	logic [7:0] tx_data = 8'h00;
	logic tx_valid = 1'b0;
	logic tx_ready;
	logic [7:0] rx_data;
	logic rx_valid;
	logic dsr_on;
	logic [7:0] rxq [$];
	logic [7:0] pat [4] = '{8'ha5, 8'h00, 8'hff, 8'h3c};
	logic [31:0] q;
	int fails = 0;
	int n_tests = 0;
	int ticks = 0;
	serial_link_if l1 ();
	serial_link_if l2 ();
	////////////////////////////////////////////////////////////////
	modem_serial_end #(.BIT_CYC(BC), .FIFO_DEPTH(8)) i_modem_serial_end (.clk_i(clk_i),
		.rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat[0]), .wb_we_i(we),
		.wb_sel_i(4'h1), .wb_cyc_i(cyc[0]), .wb_stb_i(cyc[0]), .wb_ack_o(ack[0]), .link(l1));
	modem_serial_end #(.BIT_CYC(BC), .FIFO_DEPTH(8)) i_modem_serial_end_2 (.clk_i(clk_i),
		.rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat[1]), .wb_we_i(we),
		.wb_sel_i(4'h1), .wb_cyc_i(cyc[1]), .wb_stb_i(cyc[1]), .wb_ack_o(ack[1]), .link(l2));
	host_serial_end #(.BIT_CYC(BC)) i_host_serial_end (.clk_i(clk_i), .rst_i(rst_i),
		.tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
		.rx_data_o(rx_data), .rx_valid_o(rx_valid), .dsr_on_o(dsr_on), .link(l1));
	host_serial_port_with_mux_chk #(.BIT_CYC(BC)) i_chk (.clk_i(clk_i), .rst_i(rst_i),
		.rxd(l1.rxd), .txd(l1.txd), .cts(l1.cts), .rts(l1.rts), .dtr(l1.dtr),
		.dsr(l1.dsr), .dcd(l1.dcd), .ri(l1.ri));
	always #10 clk_i = ~clk_i;
	// collect host bytes and cut a hang short
	always @(posedge clk_i) begin
		ticks <= ticks + 1;
		if (rx_valid === 1'b1) begin
			rxq.push_back(rx_data);
		end
		if (ticks == 40000) begin
			fails++;
			end_sim();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic end_sim();
		if (fails == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one classic wishbone cycle on end k, read data lands in q
	task automatic wb(input int k, input logic [3:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_i);
		adr <= a;
		we <= w;
		wdat <= d;
		cyc[k] <= 1'b1;
		do begin
			@(posedge clk_i);
		end while (ack[k] !== 1'b1);
		q = rdat[k];
		cyc[k] <= 1'b0;
	endtask
	function automatic logic ln(input int s);
		return s == 0 ? l1.rxd : (s == 1 ? l1.txd : l1.dcd);
	endfunction
	// sample one frame at mid-bit on line s
	task automatic grab(input int s, input logic [7:0] exp);
		int n;
		n = 0;
		while (ln(s) !== 1'b0 && n < 2000) begin
			@(posedge clk_i);
			n++;
		end
		repeat (BC / 2) @(posedge clk_i);
		chk(ln(s), 0);
		for (int i = 0; i < 8; i++) begin
			repeat (BC) @(posedge clk_i);
			chk(ln(s), exp[i]);
		end
		repeat (BC) @(posedge clk_i);
		chk(ln(s), 1);
	endtask
	// bench sends a frame on l2 txd (s=0) or dtr (s=1), then idles high
	task automatic drv(input int s, input logic [7:0] d, input logic stop);
		logic [10:0] f;
		f = {1'b1, stop, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge clk_i);
			if (s == 0) begin
				l2.txd <= f[i];
			end else begin
				l2.dtr <= f[i];
			end
			repeat (BC - 1) @(posedge clk_i);
		end
	endtask
	task automatic hsend(input logic [7:0] b);
		do begin
			@(posedge clk_i);
		end while (tx_ready !== 1'b1);
		tx_data <= b;
		tx_valid <= 1'b1;
		do begin
			@(posedge clk_i);
		end while (tx_ready !== 1'b1);
		tx_valid <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		wb(0, `REG_CTRL, 0, 0);
		chk(q, 32'h1);
		wb(0, `REG_STATUS, 0, 0);
		chk(q, 32'h19);
		wb(0, 4'h2, 0, 0);
		chk(q, 32'h0);
		chk({l1.rxd, l1.dsr, l1.dcd, l1.ri, l1.cts}, 5'h1e);
		chk(dsr_on, 0);
	endtask
	task automatic t_m2h();
		rxq.delete();
		for (int i = 0; i < 4; i++) begin
			wb(0, `REG_TXDATA, 1, pat[i]);
		end
		for (int i = 0; i < 4; i++) begin
			grab(0, pat[i]);
		end
		repeat (BC) @(posedge clk_i);
		chk(rxq.size(), 4);
		for (int i = 0; i < 4; i++) begin
			chk(rxq[i], pat[i]);
		end
	endtask
	task automatic t_h2m();
		hsend(8'h96);
		grab(1, 8'h96);
		repeat (BC) @(posedge clk_i);
		chk(l1.cts, 1);
		wb(0, `REG_STATUS, 0, 0);
		chk(q, 32'h1b);
		wb(0, `REG_RXDATA, 0, 0);
		chk(q, 32'h96);
		repeat (4) @(posedge clk_i);
		chk(l1.cts, 0);
	endtask
	task automatic t_fifo();
		int n;
		n = 0;
		rxq.delete();
		q = 32'h1;
		while (q[0] === 1'b1 && n < 12) begin
			wb(0, `REG_TXDATA, 1, 32'h40 + n);
			n++;
			wb(0, `REG_STATUS, 0, 0);
		end
		chk(n >= 8 && n <= 9, 1);
		wb(0, `REG_TXDATA, 1, 32'hee);
		repeat (11 * BC * (n + 1)) @(posedge clk_i);
		chk(rxq.size(), n);
		for (int i = 0; i < 8; i++) begin
			chk(rxq[i], 32'h40 + i);
		end
	endtask
	task automatic t_usb();
		wb(0, `REG_CTRL, 1, 32'h05);
		wb(1, `REG_CTRL, 1, 32'h05);
		repeat (4) @(posedge clk_i);
		chk({l1.cts, tx_ready}, 2'b10);
		drv(0, 8'h77, 1);
		wb(1, `REG_STATUS, 0, 0);
		chk(q[1], 0);
		wb(0, `REG_CTRL, 1, 32'h01);
		wb(1, `REG_CTRL, 1, 32'h01);
	endtask
	task automatic t_ferr();
		drv(0, 8'h5a, 0);
		wb(1, `REG_STATUS, 0, 0);
		chk(q[2], 1);
		wb(1, `REG_RXDATA, 0, 0);
		drv(0, 8'hc3, 1);
		wb(1, `REG_STATUS, 0, 0);
		chk(q[2:1], 2'b01);
		wb(1, `REG_RXDATA, 0, 0);
		chk(q, 32'hc3);
	endtask
	task automatic t_aux();
		wb(1, `REG_CTRL, 1, 32'h03);
		drv(1, 8'h2d, 1);
		wb(1, `REG_RXDATA, 0, 0);
		chk(q, 32'h2d);
		for (int i = 4; i < 7; i++) begin
			wb(0, `REG_CTRL, 1, 32'h1 | (32'h1 << i));
			repeat (3) @(posedge clk_i);
			chk({l1.ri, l1.dcd, l1.dsr}, 3'h7 ^ (3'h1 << (i - 4)));
			chk(dsr_on, i == 4);
		end
		wb(0, `REG_CTRL, 1, 32'h23);
		repeat (4) @(posedge clk_i);
		chk(l1.dcd, 1);
		wb(0, `REG_TXDATA, 1, 32'h69);
		grab(2, 8'h69);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		l2.txd <= 1'b1;
		l2.dtr <= 1'b1;
		l2.rts <= 1'b0;
		l2.dsr_in <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_m2h();
		t_h2m();
		t_fifo();
		t_usb();
		t_ferr();
		t_aux();
		end_sim();
	end
endmodule
